// [hdl/pci_port_inputs.v]
/*
 * port and comparator input block: group-direction port, bitwise-direction port with
 * global open-drain choice, input-only port shared with two comparators, edge detected
 * interrupt requests and timer input conditioning, all behind an axi4-lite slave.
 * assumes the pad ring resolves pins from output/enable triples and the analog
 * comparators deliver raw digital results that are asynchronous to clk_sys.
 */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
// What this block does
// - the three-line port switches all three lines between input and output together.
// - each of the eight wide-port lines has its own direction bit.
// - wide-port outputs share one drive style, push-pull or open-drain low only.
// - the input-only lines are never driven and are selected as digital or analog.
// - the input-only lines feed the four external interrupt requests and the timer input.
// - comparator two requests on both edges, comparator one only on its falling edge.
// - comparator results feed interrupts, readable port data and, for comparator one, the timer.
// - with comparators disabled the reference pin is a digital input and the second interrupt source.
// - comparators are off in stop mode, so their results are not used then.
// - every digital input is read through a register that follows its synchronised level; an undriven line is not latched.
// - requests come from falling edges of both comparator pins and the reference pin and a rising edge of pin two.
// - the timer mode makes comparator pin one a clock, a trigger (the same falling-edge pulse in both trigger modes), or a gate.
`timescale 1ns/1ns
`default_nettype none
`include "pci_regs.vh"

module pci_port_inputs (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // group direction port pins
    input  wire [2:0]  groupDirPortLinesIn,
    output reg  [2:0]  groupDirPortLinesOut,
    output reg  [2:0]  groupDirPortLinesOe_n,
    // bitwise direction port pins
    input  wire [7:0]  bitwiseDirPortLinesIn,
    output reg  [7:0]  bitwiseDirPortLinesOut,
    output reg  [7:0]  bitwiseDirPortLinesOe_n,
    // input-only port pins and comparator results
    input  wire [2:0]  inputOnlyPortLines,
    input  wire        analogInputOneCmp,
    input  wire        analogInputTwoCmp,
    // comparator power and event outputs
    output reg         comparatorPowerOn,
    output reg  [3:0]  externalInterruptRequests,
    output reg         timerInputClock,
    output reg         timerInputTrigger,
    output reg         timerInputGate
);

    ////////////////////////////////////////////////////////////////////////////
    // software state
    reg  [5:0]  ctrl;
    reg  [7:0]  p0Data;
    reg  [7:0]  p2Data;
    reg  [7:0]  p2Dir;       // 1 = input
    reg  [3:0]  eventFlags;
    wire        p0Out    = ctrl[`PCI_CTRL_P0OUT];
    wire        p2OpenDr = ctrl[`PCI_CTRL_P2OD];
    wire        analogEn = ctrl[`PCI_CTRL_ANALOG];
    wire [1:0]  timerMode = ctrl[`PCI_CTRL_TMODE_HI:`PCI_CTRL_TMODE_LO];
    wire        stopMode = ctrl[`PCI_CTRL_STOP];

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for every pin and comparator result
    reg  [15:0] syncA;
    reg  [15:0] syncB;
    reg  [2:0]  p0Hold;
    reg  [7:0]  p2Hold;
    wire [15:0] rawIn = {analogInputTwoCmp, analogInputOneCmp, inputOnlyPortLines,
                         bitwiseDirPortLinesIn, groupDirPortLinesIn};

    // pins carry no reset value; first stage only feeds the second
    always @(posedge clk_sys) begin
        syncA <= rawIn;
        syncB <= syncA;
    end

    // input register: each line takes its synchronised level every cycle, so a floating pin reads as the pad delivers it
    always @(posedge clk_sys) begin
        if (rst) begin
            p0Hold <= 3'h0;
            p2Hold <= 8'h00;
        end else begin
            p0Hold <= syncB[2:0];
            p2Hold <= syncB[10:3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input-only port source selection
    // comparators count only when enabled and powered; stop kills them
    wire cmpLive = analogEn & ~stopMode;
    wire cmpOne  = syncB[14];
    wire cmpTwo  = syncB[15];
    // line one and two read comparator results while comparators are live, high in stop, pins when analog is off
    wire srcOne  = cmpLive ? cmpOne : (analogEn ? 1'b1 : syncB[11]);
    wire srcTwo  = cmpLive ? cmpTwo : (analogEn ? 1'b1 : syncB[12]);
    // reference pin digital only when comparators are disabled
    wire srcRef  = analogEn ? 1'b1 : syncB[13];
    wire [2:0] p3Now = {srcRef, srcTwo, srcOne};

    reg  [2:0] p3Prev;
    reg  [2:0] p3Cur;
    always @(posedge clk_sys) begin
        if (rst) begin
            p3Prev <= 3'h7;
            p3Cur  <= 3'h7;
        end else begin
            p3Cur  <= p3Now;
            p3Prev <= p3Cur;
        end
    end

    // edge decode: index 0 pin two fall, 1 ref fall, 2 pin one fall, 3 pin two rise
    wire [3:0] edgeHit = { p3Cur[1] & ~p3Prev[1],
                           ~p3Cur[0] & p3Prev[0],
                           ~p3Cur[2] & p3Prev[2],
                           ~p3Cur[1] & p3Prev[1] };

    ////////////////////////////////////////////////////////////////////////////
    // event outputs and timer input conditioning
    always @(posedge clk_sys) begin
        if (rst) begin
            externalInterruptRequests <= 4'h0;
            timerInputClock           <= 1'b0;
            timerInputTrigger         <= 1'b0;
            timerInputGate            <= 1'b0;
            comparatorPowerOn         <= 1'b0;
        end else begin
            externalInterruptRequests <= edgeHit;              // one-cycle pulses
            comparatorPowerOn         <= cmpLive;
            timerInputClock           <= 1'b0;
            timerInputTrigger         <= 1'b0;
            timerInputGate            <= 1'b0;
            // pin one drives the timer in the selected role
            case (timerMode)
                `PCI_TM_CLOCK:   timerInputClock   <= edgeHit[2];
                `PCI_TM_TRIG_RE: timerInputTrigger <= edgeHit[2];
                `PCI_TM_TRIG_NR: timerInputTrigger <= edgeHit[2];
                `PCI_TM_GATE:    timerInputGate    <= p3Cur[0];
                default:         timerInputGate    <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_p2
            always @(posedge clk_sys) begin
                if (rst) begin
                    bitwiseDirPortLinesOut[gi]  <= 1'b0;
                    bitwiseDirPortLinesOe_n[gi] <= 1'b1;
                end else begin
                    // per-line direction, shared drive style
                    bitwiseDirPortLinesOut[gi]  <= p2OpenDr ? 1'b0 : p2Data[gi];
                    bitwiseDirPortLinesOe_n[gi] <= p2Dir[gi] | (p2OpenDr & p2Data[gi]);
                end
            end
        end
    endgenerate

    // group port: one enable for all three lines
    always @(posedge clk_sys) begin
        if (rst) begin
            groupDirPortLinesOut  <= 3'h0;
            groupDirPortLinesOe_n <= 3'h7;
        end else begin
            groupDirPortLinesOut  <= p0Data[2:0];
            groupDirPortLinesOe_n <= {3{~p0Out}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data taken in either order
    reg        awHave;
    reg        wHave;
    reg  [7:0] awAddr;
    reg [31:0] wData;
    reg  [3:0] wStrb;
    wire       doWrite = awHave & wHave & ~s_axi_bvalid;

    function known;
        input [7:0] a;
        begin
            known = (a == `PCI_OFF_CTRL) | (a == `PCI_OFF_P0DATA) | (a == `PCI_OFF_P2DATA) |
                    (a == `PCI_OFF_P2DIR) | (a == `PCI_OFF_P3DATA) | (a == `PCI_OFF_EVENTS);
        end
    endfunction

    // write channel capture and response
    always @(posedge clk_sys) begin
        if (rst) begin
            awHave        <= 1'b0;
            wHave         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= 32'h0;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PCI_RESP_OKAY;
        end else begin
            s_axi_awready <= ~awHave & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~wHave & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                awHave <= 1'b1;
                awAddr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wHave <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave       <= 1'b0;
                wHave        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known(awAddr) ? `PCI_RESP_OKAY : `PCI_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; event flags: hardware set beats software clear
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl       <= `PCI_CTRL_RST;
            p0Data     <= `PCI_DATA_RST;
            p2Data     <= `PCI_DATA_RST;
            p2Dir      <= `PCI_P2DIR_RST;
            eventFlags <= 4'h0;
        end else begin
            if (doWrite & wStrb[0]) begin
                case (awAddr)
                    `PCI_OFF_CTRL:   ctrl   <= wData[5:0];
                    `PCI_OFF_P0DATA: p0Data <= wData[7:0];
                    `PCI_OFF_P2DATA: p2Data <= wData[7:0];
                    `PCI_OFF_P2DIR:  p2Dir  <= wData[7:0];
                    default:         p0Data <= p0Data;
                endcase
            end
            eventFlags <= (eventFlags & ~((doWrite & wStrb[0] & (awAddr == `PCI_OFF_EVENTS))
                          ? wData[3:0] : 4'h0)) | edgeHit;
        end
    end

    // read channel: answer one cycle after the address is taken
    always @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `PCI_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= known({s_axi_araddr[7:2], 2'b00}) ? `PCI_RESP_OKAY : `PCI_RESP_SLVERR;
                case ({s_axi_araddr[7:2], 2'b00})
                    `PCI_OFF_CTRL:   s_axi_rdata <= {26'h0, ctrl};
                    `PCI_OFF_P0DATA: s_axi_rdata <= {29'h0, (p0Out ? p0Data[2:0] : p0Hold)};
                    `PCI_OFF_P2DATA: s_axi_rdata <= {24'h0, (p2Dir & p2Hold) | (~p2Dir & p2Data)};
                    `PCI_OFF_P2DIR:  s_axi_rdata <= {24'h0, p2Dir};
                    `PCI_OFF_P3DATA: s_axi_rdata <= {28'h0, p3Cur, 1'b0};
                    `PCI_OFF_EVENTS: s_axi_rdata <= {28'h0, eventFlags};
                    default:         s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pci_port_inputs
`default_nettype wire

// [hdl/pci_regs.vh]
/*
 * register offsets, field positions, reset values for the port and comparator input block.
 * assumes a 32-bit axi4-lite slave with one aligned word per register.
 */
`ifndef PCI_REGS_VH
`define PCI_REGS_VH

// byte offsets
`define PCI_OFF_CTRL      8'h00
`define PCI_OFF_P0DATA    8'h04
`define PCI_OFF_P2DATA    8'h08
`define PCI_OFF_P2DIR     8'h0c
`define PCI_OFF_P3DATA    8'h10
`define PCI_OFF_EVENTS    8'h14

// control register fields
`define PCI_CTRL_P0OUT    0
`define PCI_CTRL_P2OD     1
`define PCI_CTRL_ANALOG   2
`define PCI_CTRL_TMODE_LO 3
`define PCI_CTRL_TMODE_HI 4
`define PCI_CTRL_STOP     5
`define PCI_CTRL_W        6

// reset values: every line an input, push-pull, digital, external clock, running
`define PCI_CTRL_RST      6'h00
`define PCI_P2DIR_RST     8'hff
`define PCI_DATA_RST      8'h00

// timer input modes
`define PCI_TM_CLOCK      2'h0
`define PCI_TM_TRIG_RE    2'h1
`define PCI_TM_TRIG_NR    2'h2
`define PCI_TM_GATE       2'h3

// axi responses
`define PCI_RESP_OKAY     2'h0
`define PCI_RESP_SLVERR   2'h2

`endif

// [verif/pci_board_model.sv]
/* board circuitry on one bidirectional port: resolves the pin level.
   assumes low enable means the device drives; open-drain highs are released. */
`timescale 1ns/1ns
`default_nettype none
module pci_board_model #(parameter int W = 3) (
    // clock
    input wire logic         clk_sys,
    // device side
    input wire logic [W-1:0] pinOut,
    input wire logic [W-1:0] pinOe_n,
    // board side
    input wire logic [W-1:0] extLevel,
    input wire logic [W-1:0] extEn,
    output logic [W-1:0]     pinIn
);
logic tgl = 1'b0;
////////////////////////////////////////
// a floating line shows a changing level so a stale value never passes
always @(posedge clk_sys) tgl <= ~tgl;
assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extEn & extLevel) | (pinOe_n & ~extEn & {W{tgl}});
endmodule // pci_board_model
`default_nettype wire

// [verif/pci_port_inputs_asserts.sv]
/* checker for the port and comparator input block: pin, event and bus relations.
   assumes clk_sys rising edge and a synchronous active-high rst. */
`timescale 1ns/1ns
`default_nettype none
module pci_port_inputs_asserts (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // bus answers
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins and events
    input wire logic [2:0]  groupDirPortLinesOe_n,
    input wire logic [7:0]  bitwiseDirPortLinesOe_n,
    input wire logic [2:0]  inputOnlyPortLines,
    input wire logic        analogInputTwoCmp,
    input wire logic        comparatorPowerOn,
    input wire logic [3:0]  externalInterruptRequests,
    input wire logic        timerInputClock,
    input wire logic        timerInputTrigger
);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
////////////////////////////////////////
// edge latency allows for the two-flop sync plus pipe
a_group_dir_whole: assert property (
    groupDirPortLinesOe_n == 3'h0 || groupDirPortLinesOe_n == 3'h7) else $error("group lines split");
a_reset_all_inputs: assert property ($fell(rst) |->
    groupDirPortLinesOe_n == 3'h7 && bitwiseDirPortLinesOe_n == 8'hff) else $error("pin driven after reset");
a_pin_two_once: assert property (
    !(externalInterruptRequests[0] && externalInterruptRequests[3])) else $error("both edges at once");
a_ref_fall_irq: assert property (!comparatorPowerOn && $fell(inputOnlyPortLines[2]) |->
    ##[4:6] externalInterruptRequests[1]) else $error("reference fall lost");
a_pin_two_fall: assert property (!comparatorPowerOn && $fell(inputOnlyPortLines[1]) |->
    ##[4:6] externalInterruptRequests[0]) else $error("pin two fall lost");
a_cmp_two_rise: assert property (comparatorPowerOn && $rose(analogInputTwoCmp) |->
    ##[4:6] externalInterruptRequests[3]) else $error("comparator two rise lost");
a_timer_excl: assert property (!(timerInputClock && timerInputTrigger))
    else $error("clock and trigger together");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
c_rise_irq: cover property (externalInterruptRequests[3]);
c_ref_irq: cover property (externalInterruptRequests[1]);
c_trigger: cover property (timerInputTrigger);
endmodule // pci_port_inputs_asserts
bind pci_port_inputs pci_port_inputs_asserts i_pci_port_inputs_asserts (.*);
`default_nettype wire

// [verif/test_pci_port_inputs.sv]
/* testbench: bus tasks, pin stimulus and event checks for the port block.
   assumes 10 MHz clk_sys and registered bus answers sampled at rising edges. */
`timescale 1ns/1ns
`default_nettype none
`include "pci_regs.vh"
module test_pci_port_inputs;
logic clk_sys = 1'b0, rst = 1'b1;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'hf, externalInterruptRequests;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [2:0] groupDirPortLinesIn, groupDirPortLinesOut, groupDirPortLinesOe_n, inputOnlyPortLines = 3'h7;
logic [7:0] bitwiseDirPortLinesIn, bitwiseDirPortLinesOut, bitwiseDirPortLinesOe_n;
logic analogInputOneCmp = 1'b1, analogInputTwoCmp = 1'b0;
logic [2:0] grpLevel = 3'h5;
logic comparatorPowerOn, timerInputClock, timerInputTrigger, timerInputGate;
int num_errors = 0, compares = 0, clkCnt = 0, trigCnt = 0, c0, t0;
logic [7:0] ev [4] = '{8'h8, 8'h1, 8'h4, 8'h0};
pci_port_inputs i_pci_port_inputs (.*);
pci_board_model #(.W(3)) i_pci_board_model_g (.clk_sys(clk_sys), .pinOut(groupDirPortLinesOut),
    .pinOe_n(groupDirPortLinesOe_n), .extLevel(grpLevel), .extEn(3'h7), .pinIn(groupDirPortLinesIn));
pci_board_model #(.W(8)) i_pci_board_model_w (.clk_sys(clk_sys), .pinOut(bitwiseDirPortLinesOut),
    .pinOe_n(bitwiseDirPortLinesOe_n), .extLevel(8'h3c), .extEn(8'hf0), .pinIn(bitwiseDirPortLinesIn));
////////////////////////////////////////
// clock and timer pulse counters
initial forever #50 clk_sys = ~clk_sys;
always @(posedge clk_sys) begin
    clkCnt += timerInputClock;
    trigCnt += timerInputTrigger;
end
task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
        num_errors++;
        $display("CHECK FAILED %0t %s", $time, m);
    end
endtask
// holds each channel until its own ready, then one idle edge
task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (1) begin
        @(posedge clk_sys);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
    end
    chk(s_axi_bresp, er, "write response");
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
endtask
task rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (1) begin
        @(posedge clk_sys);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
    end
    chk(s_axi_rdata & mask, exp, "read data");
    chk(s_axi_rresp, er, "read response");
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
endtask
task results;
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
////////////////////////////////////////
// main sequence
initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({groupDirPortLinesOe_n, bitwiseDirPortLinesOe_n}, 32'h7ff, "reset drive");
    rd(`PCI_OFF_P2DIR, 32'hff, 32'hff, `PCI_RESP_OKAY);
    rd(`PCI_OFF_P0DATA, 32'h7, 32'h5, `PCI_RESP_OKAY);
    grpLevel <= 3'h2;
    repeat (4) @(posedge clk_sys);
    rd(`PCI_OFF_P0DATA, 32'h7, 32'h2, `PCI_RESP_OKAY);
    wr(`PCI_OFF_P0DATA, 32'h5, `PCI_RESP_OKAY);
    wr(`PCI_OFF_CTRL, 32'h1, `PCI_RESP_OKAY);
    chk({groupDirPortLinesOe_n, groupDirPortLinesOut}, 32'h05, "group output");
    wr(`PCI_OFF_P2DIR, 32'h5a, `PCI_RESP_OKAY);
    wr(`PCI_OFF_P2DATA, 32'h0f, `PCI_RESP_OKAY);
    chk({bitwiseDirPortLinesOe_n, bitwiseDirPortLinesOut & 8'ha5}, 32'h5a05, "push-pull");
    s_axi_wstrb <= 4'h0;
    wr(`PCI_OFF_P2DIR, 32'h0, `PCI_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`PCI_OFF_P2DIR, 32'hff, 32'h5a, `PCI_RESP_OKAY);
    wr(`PCI_OFF_CTRL, 32'h3, `PCI_RESP_OKAY);
    chk({bitwiseDirPortLinesOe_n, bitwiseDirPortLinesOut}, 32'h5f00, "open-drain");
    wr(8'h40, 32'h1, `PCI_RESP_SLVERR);
    rd(8'h40, 32'hffffffff, 32'h0, `PCI_RESP_SLVERR);
    inputOnlyPortLines <= 3'h5;
    repeat (8) @(posedge clk_sys);
    rd(`PCI_OFF_P3DATA, 32'he, 32'ha, `PCI_RESP_OKAY);
    wr(`PCI_OFF_EVENTS, 32'hf, `PCI_RESP_OKAY);
    inputOnlyPortLines <= 3'h1;
    repeat (8) @(posedge clk_sys);
    rd(`PCI_OFF_EVENTS, 32'hf, 32'h2, `PCI_RESP_OKAY);
    wr(`PCI_OFF_CTRL, 32'h4, `PCI_RESP_OKAY);
    chk(comparatorPowerOn, 1'b1, "comparators on");
    // rise and fall of each comparator against its sticky flag
    for (int i = 0; i < 4; i++) begin
        repeat (8) @(posedge clk_sys);
        wr(`PCI_OFF_EVENTS, 32'hf, `PCI_RESP_OKAY);
        analogInputOneCmp <= (i != 2);
        analogInputTwoCmp <= (i == 0);
        repeat (8) @(posedge clk_sys);
        rd(`PCI_OFF_EVENTS, 32'hf, ev[i], `PCI_RESP_OKAY);
    end
    for (int m = 0; m < 4; m++) begin
        wr(`PCI_OFF_CTRL, 32'h4 | (m << 3), `PCI_RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        chk(timerInputGate, m == 3, "gate level");
        c0 = clkCnt; t0 = trigCnt;
        analogInputOneCmp <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(clkCnt - c0, m == 0, "timer clock pulses");
        chk(trigCnt - t0, m == 1 || m == 2, "timer trigger pulses");
        analogInputOneCmp <= 1'b1;
    end
    wr(`PCI_OFF_CTRL, 32'h24, `PCI_RESP_OKAY);
    chk(comparatorPowerOn, 1'b0, "stop power");
    results;
end
initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    results;
end
endmodule // test_pci_port_inputs
`default_nettype wire
